// *** hw/tcsp_pkg.sv ***
// Shared constants and types for the converter command and status port
// What this block does
// - Power-on reset opcode 0x50 resets the walk state, every status flag and every configuration word
// - Init opcode 0x70 prepares a new measurement and keeps configuration words
// - Store command copies all configuration words into the nonvolatile image
// - Load command fills configuration words from the nonvolatile image
// - A status flag shows configuration words equal to the nonvolatile image
// - Separate flags for corrected single errors and uncorrectable multiple errors
// - Separate flags for shorted sensor and open sensor on temperature port
// - In long-range mode a precounter overflow sets a timeout flag
// - An overflow of the fine time unit sets a timeout flag
package tcsp_pkg;
  localparam int CFG_WORDS = 7;
  localparam int CFG_W = 32;
  localparam int IDX_W = 3;
  localparam int STAT_W = 16;
  localparam logic [IDX_W-1:0] LAST_IDX = IDX_W'(CFG_WORDS - 1);
  // Command opcodes
  localparam logic [7:0] OP_POR = 8'h50;
  localparam logic [7:0] OP_INIT = 8'h70;
  localparam logic [7:0] OP_WRCFG = 8'h80;
  localparam logic [7:0] OP_WRCFG_MASK = 8'hF8;
  localparam logic [7:0] OP_RDSTAT = 8'hB4;
  localparam logic [7:0] OP_NVM_STORE = 8'hC0;
  localparam logic [7:0] OP_NVM_LOAD = 8'hF0;
  localparam logic [7:0] OP_NVM_CMP = 8'hC6;
  localparam logic [2:0] WRCFG_LAST_BYTE = 3'h4;
  // Reset values
  localparam logic [CFG_W-1:0] CFG_RST = 32'h0000_0000;
  localparam logic [STAT_W-1:0] STAT_RST = 16'h0000;
  // Field positions
  localparam int CFG_MODE2_BIT = 0;
  localparam int ST_FINE_OVF = 0;
  localparam int ST_PRECNT_OVF = 1;
  localparam int ST_SENS_OPEN = 2;
  localparam int ST_SENS_SHORT = 3;
  localparam int ST_NVM_CORR = 4;
  localparam int ST_NVM_UNCORR = 5;
  localparam int ST_NVM_MATCH = 6;
  typedef enum logic [1:0] {TCSP_IDLE, TCSP_STORE, TCSP_READ, TCSP_WAIT} tcsp_state_t;
endpackage : tcsp_pkg

// *** hw/tcsp_nvm_if.sv ***
// Request and answer signals between the command logic and the nonvolatile store
`timescale 1ns/1ps
`default_nettype none
interface tcsp_nvm_if #(parameter int IDX_W = 3, parameter int W = 32);
  logic wr;
  logic rd;
  logic [IDX_W-1:0] idx;
  logic [W-1:0] wdata;
  logic [W-1:0] rdata;
  logic rvalid;
  logic err_single;
  logic err_double;
  modport host (output wr, rd, idx, wdata, input rdata, rvalid, err_single, err_double);
  modport store (input wr, rd, idx, wdata, output rdata, rvalid, err_single, err_double);
endinterface : tcsp_nvm_if
`default_nettype wire

// *** hw/tcsp_nvm.sv ***
// Nonvolatile configuration image: two parity-protected copies per word
`timescale 1ns/1ps
`default_nettype none
module tcsp_nvm
  import tcsp_pkg::*;
#(
  parameter int DEPTH = CFG_WORDS
) (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic upset_a,
  input wire logic upset_b,
  tcsp_nvm_if.store nvm
);
  // Unpacked, so that each word's process owns its own entry and no two processes share a variable
  logic [CFG_W:0] copy_a_r [DEPTH];
  logic [CFG_W:0] copy_b_r [DEPTH];
  logic upa_d_r;
  logic upb_d_r;
  logic ok_a;
  logic ok_b;

  // Parity bit sits on top; a copy is good when its overall parity is even
  assign ok_a = ~^copy_a_r[nvm.idx];
  assign ok_b = ~^copy_b_r[nvm.idx];

  // Upset strobes are already synchronised; edge gives a one-shot bit flip in word 0
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      upa_d_r <= 1'b0;
      upb_d_r <= 1'b0;
    end else begin
      upa_d_r <= upset_a;
      upb_d_r <= upset_b;
    end
  end

  // Storage; contents are not cleared by reset, as a real image survives it
  genvar g;
  for (g = 0; g < DEPTH; g++) begin : g_word
    always_ff @(posedge sys_clk) begin
      if (nvm.wr && nvm.idx == IDX_W'(g)) begin
        copy_a_r[g] <= {^nvm.wdata, nvm.wdata};
        copy_b_r[g] <= {^nvm.wdata, nvm.wdata};
      end else if (g == 0) begin
        if (upset_a && !upa_d_r) copy_a_r[g][0] <= ~copy_a_r[g][0];
        if (upset_b && !upb_d_r) copy_b_r[g][0] <= ~copy_b_r[g][0];
      end
    end
  end

  // One-cycle read answer; bad copy A falls back to copy B as a corrected error
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      nvm.rvalid <= 1'b0;
      nvm.rdata <= CFG_RST;
      nvm.err_single <= 1'b0;
      nvm.err_double <= 1'b0;
    end else begin
      nvm.rvalid <= nvm.rd;
      if (nvm.rd) begin
        nvm.rdata <= ok_a ? copy_a_r[nvm.idx][CFG_W-1:0] : copy_b_r[nvm.idx][CFG_W-1:0];
        nvm.err_single <= !ok_a && ok_b;
        nvm.err_double <= !ok_a && !ok_b;
      end
    end
  end
endmodule : tcsp_nvm
`default_nettype wire

// *** hw/tcsp_top.sv ***
// Command interpreter and status word of the converter, reached over a serial port
`timescale 1ns/1ps
`default_nettype none
module tcsp_top
  import tcsp_pkg::*;
(
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic spi_sclk,
  input wire logic spi_csn,
  input wire logic spi_mosi,
  output logic spi_miso,
  output logic spi_miso_oe,
  input wire logic fine_ovf_evt,
  input wire logic precnt_ovf_evt,
  input wire logic sens_short_evt,
  input wire logic sens_open_evt,
  input wire logic nvm_upset_a,
  input wire logic nvm_upset_b,
  output logic meas_init,
  output logic [CFG_WORDS*CFG_W-1:0] cfg_image,
  output logic [STAT_W-1:0] status_word
);
  localparam int AWR_MAX = 10;
  localparam int ALD_MAX = 16;

  logic [2:0] sclk_s_r;
  logic [1:0] csn_s_r;
  logic [1:0] mosi_s_r;
  logic [1:0] upa_s_r;
  logic [1:0] upb_s_r;
  logic sclk_rise;
  logic sclk_fall;
  logic active;
  logic [2:0] bit_cnt_r;
  logic [2:0] byte_cnt_r;
  logic [7:0] shin_r;
  logic [7:0] op_r;
  logic [23:0] acc_r;
  logic [STAT_W-1:0] shout_r;
  logic [7:0] rx_byte;
  logic byte_done;
  logic first_byte;
  logic cmd_por;
  logic cmd_init;
  logic cmd_store;
  logic cmd_load;
  logic cmd_cmp;
  logic cmd_rdstat;
  logic cmd_known;
  logic cfg_wr_en;
  logic [CFG_WORDS-1:0][CFG_W-1:0] cfg_r;
  logic [STAT_W-1:0] status_r;
  tcsp_state_t state_r;
  logic [IDX_W-1:0] widx_r;
  logic cmp_op_r;
  logic cmp_eq_r;
  logic nvm_done;

  tcsp_nvm_if #(.IDX_W(IDX_W), .W(CFG_W)) nvm ();

  tcsp_nvm #(.DEPTH(CFG_WORDS)) u_nvm (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .upset_a(upa_s_r[1]),
    .upset_b(upb_s_r[1]),
    .nvm(nvm.store)
  );

  // Pins come from the host's domain: two flops before any logic looks at them
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      sclk_s_r <= 3'h0;
      csn_s_r <= 2'h3;
      mosi_s_r <= 2'h0;
      upa_s_r <= 2'h0;
      upb_s_r <= 2'h0;
    end else begin
      sclk_s_r <= {sclk_s_r[1:0], spi_sclk};
      csn_s_r <= {csn_s_r[0], spi_csn};
      mosi_s_r <= {mosi_s_r[0], spi_mosi};
      upa_s_r <= {upa_s_r[0], nvm_upset_a};
      upb_s_r <= {upb_s_r[0], nvm_upset_b};
    end
  end

  // Edges use only the second and third stage, never the first
  assign sclk_rise = sclk_s_r[1] && !sclk_s_r[2];
  assign sclk_fall = !sclk_s_r[1] && sclk_s_r[2];
  assign active = !csn_s_r[1];
  assign rx_byte = {shin_r[6:0], mosi_s_r[1]};
  assign byte_done = active && sclk_rise && bit_cnt_r == 3'h7;
  assign first_byte = byte_done && byte_cnt_r == 3'h0;

  // Command decode; opcode acts on the rising edge that completes its byte
  assign cmd_por = first_byte && rx_byte == OP_POR;
  assign cmd_init = first_byte && rx_byte == OP_INIT;
  assign cmd_store = first_byte && rx_byte == OP_NVM_STORE && state_r == TCSP_IDLE;
  assign cmd_load = first_byte && rx_byte == OP_NVM_LOAD && state_r == TCSP_IDLE;
  assign cmd_cmp = first_byte && rx_byte == OP_NVM_CMP && state_r == TCSP_IDLE;
  assign cmd_rdstat = first_byte && rx_byte == OP_RDSTAT;
  assign cmd_known = cmd_por || cmd_init || cmd_rdstat || rx_byte == OP_NVM_STORE ||
                     rx_byte == OP_NVM_LOAD || rx_byte == OP_NVM_CMP ||
                     (rx_byte & OP_WRCFG_MASK) == OP_WRCFG;
  // Word writes landing beyond the last word, or during a store walk, are dropped
  assign cfg_wr_en = byte_done && byte_cnt_r == WRCFG_LAST_BYTE && (op_r & OP_WRCFG_MASK) == OP_WRCFG &&
                     int'(op_r[IDX_W-1:0]) < CFG_WORDS && state_r == TCSP_IDLE;

  // Serial receive: bit and byte counters restart with every chip select
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      bit_cnt_r <= 3'h0;
      byte_cnt_r <= 3'h0;
      shin_r <= 8'h00;
      op_r <= 8'h00;
      acc_r <= 24'h00_0000;
    end else if (!active) begin
      bit_cnt_r <= 3'h0;
      byte_cnt_r <= 3'h0;
    end else if (sclk_rise) begin
      shin_r <= rx_byte;
      bit_cnt_r <= bit_cnt_r + 3'h1;
      if (byte_done) begin
        acc_r <= {acc_r[15:0], rx_byte};
        if (byte_cnt_r != 3'h7) byte_cnt_r <= byte_cnt_r + 3'h1;
        if (first_byte) op_r <= rx_byte; // Unknown opcodes land here but steer nothing
      end
    end
  end

  // Serial transmit: status is snapshotted at the opcode, MSB first on falling edges
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      shout_r <= STAT_RST;
      spi_miso <= 1'b0;
      spi_miso_oe <= 1'b0;
    end else begin
      spi_miso_oe <= active;
      if (cmd_rdstat) begin
        shout_r <= status_r;
      end else if (active && sclk_fall) begin
        spi_miso <= shout_r[STAT_W-1];
        shout_r <= {shout_r[STAT_W-2:0], 1'b0};
      end
    end
  end

  // Measurement restart pulse for both init and power-on reset
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) meas_init <= 1'b0;
    else meas_init <= cmd_init || cmd_por;
  end

  // Walk over all words, one per cycle for store, two per word for read paths
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      state_r <= TCSP_IDLE;
      widx_r <= '0;
      cmp_op_r <= 1'b0;
    end else if (cmd_por) begin
      state_r <= TCSP_IDLE; // Power-on reset aborts any walk
      widx_r <= '0;
    end else begin
      case (state_r)
        TCSP_IDLE: begin
          widx_r <= '0;
          if (cmd_store) state_r <= TCSP_STORE;
          if (cmd_load || cmd_cmp) state_r <= TCSP_READ;
          if (cmd_load || cmd_cmp) cmp_op_r <= cmd_cmp;
        end
        TCSP_STORE: begin
          widx_r <= widx_r + IDX_W'(1);
          if (widx_r == LAST_IDX) state_r <= TCSP_IDLE;
        end
        TCSP_READ: state_r <= TCSP_WAIT;
        TCSP_WAIT: begin
          if (nvm.rvalid) begin
            widx_r <= widx_r + IDX_W'(1);
            state_r <= widx_r == LAST_IDX ? TCSP_IDLE : TCSP_READ;
          end
        end
        default: state_r <= TCSP_IDLE;
      endcase
    end
  end

  assign nvm.wr = state_r == TCSP_STORE;
  assign nvm.rd = state_r == TCSP_READ;
  assign nvm.idx = widx_r;
  assign nvm.wdata = cfg_r[widx_r];
  assign nvm_done = (state_r == TCSP_STORE || (state_r == TCSP_WAIT && nvm.rvalid)) && widx_r == LAST_IDX;

  // Running equality over a compare walk
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) cmp_eq_r <= 1'b1;
    else if (state_r == TCSP_IDLE) cmp_eq_r <= 1'b1;
    else if (state_r == TCSP_WAIT && nvm.rvalid && nvm.rdata != cfg_r[widx_r]) cmp_eq_r <= 1'b0;
  end

  // Configuration words: cleared by power-on reset, untouched by init
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      cfg_r <= {CFG_WORDS{CFG_RST}};
    end else if (cmd_por) begin
      cfg_r <= {CFG_WORDS{CFG_RST}};
    end else if (cfg_wr_en) begin
      cfg_r[op_r[IDX_W-1:0]] <= {acc_r, rx_byte};
    end else if (state_r == TCSP_WAIT && nvm.rvalid && !cmp_op_r && !nvm.err_double) begin
      cfg_r[widx_r] <= nvm.rdata; // An uncorrectable word is not loaded
    end
  end
  assign cfg_image = cfg_r;

  // Sticky status; an event in the clearing cycle still sets its flag
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      status_r <= STAT_RST;
    end else begin
      if (cmd_por || cmd_init) status_r[ST_FINE_OVF] <= 1'b0;
      if (fine_ovf_evt) status_r[ST_FINE_OVF] <= 1'b1;
      if (cmd_por || cmd_init) status_r[ST_PRECNT_OVF] <= 1'b0;
      if (precnt_ovf_evt && cfg_r[0][CFG_MODE2_BIT]) status_r[ST_PRECNT_OVF] <= 1'b1;
      if (cmd_por || cmd_init) status_r[ST_SENS_OPEN] <= 1'b0;
      if (sens_open_evt) status_r[ST_SENS_OPEN] <= 1'b1;
      if (cmd_por || cmd_init) status_r[ST_SENS_SHORT] <= 1'b0;
      if (sens_short_evt) status_r[ST_SENS_SHORT] <= 1'b1;
      if (cmd_por || cmd_load || cmd_cmp) status_r[ST_NVM_CORR] <= 1'b0;
      if (state_r == TCSP_WAIT && nvm.rvalid && nvm.err_single) status_r[ST_NVM_CORR] <= 1'b1;
      if (cmd_por || cmd_load || cmd_cmp) status_r[ST_NVM_UNCORR] <= 1'b0;
      if (state_r == TCSP_WAIT && nvm.rvalid && nvm.err_double) status_r[ST_NVM_UNCORR] <= 1'b1;
      // Any change to the words makes a previous match stale
      if (cmd_por || cfg_wr_en || cmd_load || cmd_cmp) status_r[ST_NVM_MATCH] <= 1'b0;
      if (nvm_done) status_r[ST_NVM_MATCH] <= state_r == TCSP_STORE || (cmp_op_r ? cmp_eq_r &&
        nvm.rdata == cfg_r[widx_r] : !nvm.err_double && !status_r[ST_NVM_UNCORR]);
    end
  end
  assign status_word = status_r;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  AST_POR_CLEARS_CFG: assert property (cmd_por |=> cfg_image == {CFG_WORDS{CFG_RST}} && state_r == TCSP_IDLE)
    else $error("power-on reset left configuration or walk state");
  AST_INIT_KEEPS_CFG: assert property (cmd_init && state_r == TCSP_IDLE |=> $stable(cfg_image) ##0 meas_init)
    else $error("init changed configuration or gave no restart pulse");
  AST_STORE_MATCH: assert property (cmd_store |-> ##[1:AWR_MAX] status_word[ST_NVM_MATCH])
    else $error("store walk did not end with a match");
  AST_LOAD_WORD: assert property (state_r == TCSP_WAIT && nvm.rvalid && !cmp_op_r
    && !nvm.err_double && !cmd_por |=> cfg_r[$past(widx_r)] == $past(nvm.rdata))
    else $error("loaded word differs from image");
  AST_LOAD_ENDS: assert property (cmd_load |-> ##[1:ALD_MAX] state_r == TCSP_IDLE)
    else $error("load walk did not finish");
  AST_MATCH_STALE: assert property (cfg_wr_en && !nvm_done |=> !status_word[ST_NVM_MATCH])
    else $error("match flag kept after a configuration write");
  AST_NVM_ERR: assert property (state_r == TCSP_WAIT && nvm.rvalid && nvm.err_double && !cmd_por
    |=> status_word[ST_NVM_UNCORR] && !$past(nvm.err_single))
    else $error("uncorrectable error not flagged");
  // Sensor and fine overflow events must raise their own flags, precounter only in long-range mode; set wins over a clear in the same cycle
  AST_SENSOR: assert property (sens_short_evt || sens_open_evt
    |=> (!$past(sens_short_evt) || status_word[ST_SENS_SHORT]) &&
    (!$past(sens_open_evt) || status_word[ST_SENS_OPEN]))
    else $error("sensor fault not flagged");
  AST_PRECNT: assert property (precnt_ovf_evt && !cfg_r[0][CFG_MODE2_BIT] && !status_word[ST_PRECNT_OVF]
    |=> !status_word[ST_PRECNT_OVF])
    else $error("precounter flag set outside long-range mode");
  AST_FINE: assert property (fine_ovf_evt |=> status_word[ST_FINE_OVF])
    else $error("fine overflow not flagged");
  AST_UNKNOWN_OP: assert property (first_byte && !cmd_known && state_r == TCSP_IDLE
    |=> $stable(cfg_image) && !meas_init && state_r == TCSP_IDLE)
    else $error("unknown opcode had an effect");

  COV_POR_INIT: cover property (cmd_por ##[1:1000] cfg_wr_en ##[1:1000] cmd_init);
  COV_COMPARE_HIT: cover property (cmd_cmp ##[1:ALD_MAX] status_word[ST_NVM_MATCH]);
  COV_CORRECTED: cover property ($rose(status_word[ST_NVM_CORR]));
  COV_STATUS_READ: cover property (cmd_rdstat ##[1:1000] sclk_fall);
endmodule : tcsp_top
`default_nettype wire

// *** verification/tcsp_host.sv ***
// Serial host model: mode 0 master that frames opcodes and data bytes
`timescale 1ns/1ps
`default_nettype none
module tcsp_host (
  input wire logic sys_clk,
  output logic spi_sclk,
  output logic spi_csn,
  output logic spi_mosi,
  input wire logic spi_miso,
  input wire logic spi_miso_oe
);
  // Half period in sys_clk cycles; the bench may slow the host down
  int half = 6;
  logic [15:0] shift_r;
  // Idle: select high, clock low; the clock stands still outside frames
  initial begin
    spi_sclk = 1'b0;
    spi_csn = 1'b1;
    spi_mosi = 1'b0;
    shift_r = 16'h0000;
  end
  task tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask : tick
  // Data set while the clock is low, answer taken just before the rise
  task xbit(input logic b);
    spi_mosi <= b;
    tick(half);
    shift_r = {shift_r[14:0], spi_miso_oe ? spi_miso : 1'b1};
    spi_sclk <= 1'b1;
    tick(half);
    spi_sclk <= 1'b0;
  endtask : xbit
  // Opcode, then nb data bytes MSB first; the last 16 bits seen come back
  task frame(input logic [7:0] op, input int nb, input logic [31:0] d, output logic [15:0] rd);
    spi_csn <= 1'b0;
    tick(half);
    for (int i = 7; i >= 0; i--) xbit(op[i]);
    for (int i = 8 * nb - 1; i >= 0; i--) xbit(d[i]);
    tick(half);
    spi_csn <= 1'b1;
    spi_mosi <= ~spi_mosi; // Released line shows no stale level
    tick(2 * half);
    rd = shift_r;
  endtask : frame
endmodule : tcsp_host
`default_nettype wire

// *** verification/tcsp_top_tb.sv ***
// Self-checking bench for the converter command and status port
`timescale 1ns/1ps
`default_nettype none
module tcsp_top_tb
  import tcsp_pkg::*;
;
  logic sys_clk, resetn, got_stb, nvm_upset_a, nvm_upset_b, meas_init;
  logic fine_ovf_evt, precnt_ovf_evt, sens_short_evt, sens_open_evt;
  wire spi_sclk, spi_csn, spi_mosi, spi_miso, spi_miso_oe;
  logic [CFG_WORDS*CFG_W-1:0] cfg_image, exp_img, save_img;
  logic [STAT_W-1:0] status_word, got, rd;
  logic [31:0] exp_q[$];
  logic [31:0] note, rnd;
  logic [7:0] n_init;
  int n_errors = 0;
  int n_compared = 0;
  tcsp_top u_tcsp_top (.sys_clk(sys_clk), .resetn(resetn), .spi_sclk(spi_sclk), .spi_csn(spi_csn),
    .spi_mosi(spi_mosi), .spi_miso(spi_miso), .spi_miso_oe(spi_miso_oe), .fine_ovf_evt(fine_ovf_evt),
    .precnt_ovf_evt(precnt_ovf_evt), .sens_short_evt(sens_short_evt), .sens_open_evt(sens_open_evt),
    .nvm_upset_a(nvm_upset_a), .nvm_upset_b(nvm_upset_b), .meas_init(meas_init), .cfg_image(cfg_image),
    .status_word(status_word));
  tcsp_host u_tcsp_host (.sys_clk(sys_clk), .spi_sclk(spi_sclk), .spi_csn(spi_csn), .spi_mosi(spi_mosi),
    .spi_miso(spi_miso), .spi_miso_oe(spi_miso_oe));
  // 125 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  // Counts one-cycle start pulses so none can slip by unseen
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) n_init <= 8'h00;
    else if (meas_init === 1'b1) n_init <= n_init + 8'h01;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], 1'b0} ^ (x[31] ? 32'h0040_0007 : 32'h0000_0000);
  endfunction : lfsr
  task results;
    if (n_errors == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : results
  task mis(input logic [31:0] g, input logic [31:0] e);
    n_errors++;
    $display("mismatch at %0t: got %h expected %h", $time, g, e);
  endtask : mis
  task chk_stat(input logic [15:0] g, input logic [15:0] e, input logic [15:0] m);
    n_compared++;
    if ((g & m) !== (e & m)) mis({16'h0000, g}, {16'h0000, e});
  endtask : chk_stat
  task chk_cfg;
    n_compared++;
    for (int i = 0; i < CFG_WORDS; i++)
      if (cfg_image[CFG_W*i +: CFG_W] !== exp_img[CFG_W*i +: CFG_W])
        mis(cfg_image[CFG_W*i +: CFG_W], exp_img[CFG_W*i +: CFG_W]);
  endtask : chk_cfg
  task chk_init(input logic [7:0] e);
    n_compared++;
    if (n_init !== e) mis({24'h0, n_init}, {24'h0, e});
  endtask : chk_init
  // Watcher: each status answer is matched against the oldest note
  always @(posedge got_stb) begin
    if (exp_q.size() == 0) mis({16'h0000, got}, 32'h0);
    else begin
      note = exp_q.pop_front();
      chk_stat(got, note[31:16], note[15:0]);
    end
  end
  task cmd(input logic [7:0] op);
    u_tcsp_host.frame(op, 0, 32'h0000_0000, rd);
  endtask : cmd
  task wr(input logic [IDX_W-1:0] i, input logic [31:0] d);
    u_tcsp_host.frame(OP_WRCFG | {5'h00, i}, 4, d, rd);
    exp_img[CFG_W*i +: CFG_W] = d;
  endtask : wr
  task rd_stat(input logic [15:0] e, input logic [15:0] m);
    exp_q.push_back({e, m});
    u_tcsp_host.frame(OP_RDSTAT, 2, 32'h0000_0000, rd);
    got <= rd;
    got_stb <= 1'b1;
    @(posedge sys_clk);
    got_stb <= 1'b0;
  endtask : rd_stat
  // Event bits: 0 fine, 1 precounter, 2 open sensor, 3 shorted sensor
  task ev(input logic [3:0] m);
    @(posedge sys_clk);
    {sens_short_evt, sens_open_evt, precnt_ovf_evt, fine_ovf_evt} <= m;
    @(posedge sys_clk);
    {sens_short_evt, sens_open_evt, precnt_ovf_evt, fine_ovf_evt} <= 4'h0;
    repeat (4) @(posedge sys_clk);
  endtask : ev
  // Upset pins are synchronised inside, so hold them a few cycles
  task upset(input logic b);
    @(posedge sys_clk);
    if (b) nvm_upset_b <= 1'b1;
    else nvm_upset_a <= 1'b1;
    repeat (4) @(posedge sys_clk);
    {nvm_upset_a, nvm_upset_b} <= 2'b00;
    repeat (4) @(posedge sys_clk);
  endtask : upset
  // Load and compare walks take 14 cycles, a store walk 7; give ample margin
  task settle;
    repeat (40) @(posedge sys_clk);
  endtask : settle
  // Hang guard
  initial begin
    repeat (100000) @(posedge sys_clk);
    n_errors++;
    results;
  end
  initial begin
    {fine_ovf_evt, precnt_ovf_evt, sens_short_evt, sens_open_evt} = 4'h0;
    {nvm_upset_a, nvm_upset_b, got_stb} = 3'b000;
    got = 16'h0000;
    resetn = 1'b0;
    exp_img = '0;
    rnd = 32'h4d9f_3abe;
    repeat (6) @(posedge sys_clk);
    resetn <= 1'b1;
    repeat (3) @(posedge sys_clk);
    chk_cfg;
    rd_stat(STAT_RST, 16'hffff);
    cmd(OP_POR);
    chk_init(8'h01);
    ev(4'h2);
    rd_stat(16'h0000, 16'hffff);
    for (int i = 0; i < CFG_WORDS; i++) begin
      rnd = lfsr(rnd);
      wr(IDX_W'(i), (i == 0) ? (rnd | 32'h0000_0001) : rnd);
    end
    u_tcsp_host.frame(OP_WRCFG | 8'h07, 4, lfsr(rnd), rd);
    chk_cfg;
    cmd(OP_INIT);
    chk_init(8'h02);
    chk_cfg;
    // Each fault flag alone; init clears the previous one
    for (int k = 0; k < 4; k++) begin
      cmd(OP_INIT);
      ev(4'h1 << k);
      rd_stat(16'h0001 << k, 16'hffff);
    end
    cmd(OP_INIT);
    chk_init(8'h07);
    cmd(OP_NVM_STORE);
    settle;
    rd_stat(16'h0040, 16'hffff);
    save_img = exp_img;
    rnd = lfsr(rnd);
    wr(3'h3, ~save_img[CFG_W*3 +: CFG_W]);
    rd_stat(16'h0000, 16'hffff);
    cmd(OP_NVM_CMP);
    settle;
    rd_stat(16'h0000, 16'hffff);
    u_tcsp_host.half = 11;
    cmd(OP_NVM_LOAD);
    settle;
    exp_img = save_img;
    chk_cfg;
    rd_stat(16'h0040, 16'hffff);
    cmd(8'h33);
    chk_cfg;
    rd_stat(16'h0040, 16'hffff);
    chk_init(8'h07);
    upset(1'b0);
    cmd(OP_NVM_LOAD);
    settle;
    chk_cfg;
    rd_stat(16'h0050, 16'hffff);
    upset(1'b1);
    wr(3'h0, rnd);
    cmd(OP_NVM_LOAD);
    settle;
    chk_cfg;
    rd_stat(16'h0020, 16'hffff);
    cmd(OP_POR);
    exp_img = '0;
    chk_cfg;
    rd_stat(16'h0000, 16'hffff);
    chk_init(8'h08);
    results;
  end
endmodule : tcsp_top_tb
`default_nettype wire
